// ==== design/pcs_tx_cfg.svh ====
// constants for the ethernet pcs transmit code inserter
`ifndef PCS_TX_CFG_SVH
`define PCS_TX_CFG_SVH
`define G_COMMA 8'hbc
`define G_PRESERVE 8'h50
`define G_CORRECT 8'hc5
`define G_START 8'hfb
`define G_END 8'hfd
`define G_EXTEND 8'hf7
`define PREAMBLE_BYTE 8'h55
`define SFD_BYTE 8'hd5
`define UNDERRUN_BYTE 8'h00
`define X_IDLE_CODE 8'h07
`define X_START_CODE 8'hfb
`define X_TERM_CODE 8'hfd
`define G_PRE_LAST 3'h6
`define CRC_LAST 3'h3
`define CRC_INIT 32'hffffffff
`define CRC_POLY 32'hedb88320
`define XG_LANES 8
`endif

// ==== design/pcs_tx_pkg.sv ====
// state types of the pcs transmit code inserter
package pcs_tx_pkg;
   typedef enum logic [3:0] {
      G_IDLE_K, G_IDLE_D, G_START, G_PRE, G_SFD, G_DATA,
      G_CRC, G_TERM, G_EXT, G_CORR_K, G_CORR_D
   } gig_state_type;
   typedef enum logic [1:0] {
      X_IDLE, X_DATA, X_TERM
   } xg_state_type;
endpackage

// ==== design/crc32_byte.sv ====
// ethernet crc-32 register that absorbs one byte per clock
`timescale 1ns/1ps
`include "pcs_tx_cfg.svh"
module crc32_byte (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_init,
   input wire logic i_en,
   input wire logic [7:0] i_data,
   output logic [31:0] o_crc
);
   logic [31:0] crc_reg;
   logic [31:0] crc_next;

   // reflected form: bits enter lsb first, matching the order on the wire
   function automatic logic [31:0] step_byte(input logic [31:0] c, input logic [7:0] d);
      logic [31:0] v;
      v = c ^ {24'h000000, d};
      for (int b = 0; b < 8; b++) begin
         v = v[0] ? ((v >> 1) ^ `CRC_POLY) : (v >> 1);
      end
      return v;
   endfunction

   assign crc_next = step_byte(crc_reg, i_data);

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         crc_reg <= `CRC_INIT;
      end else if (i_init) begin
         crc_reg <= `CRC_INIT;
      end else if (i_en) begin
         crc_reg <= crc_next;
      end
   end

   assign o_crc = crc_reg;
endmodule // crc32_byte

// ==== design/pcs_tx_inserter.sv ====
// 1G and 10G transmit paths that wrap frames in pcs control codes
`timescale 1ns/1ps
`include "pcs_tx_cfg.svh"
module pcs_tx_inserter
   import pcs_tx_pkg::*;
#(
   parameter int LANES = `XG_LANES
) (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_g_valid,
   input wire logic [7:0] i_g_data,
   input wire logic i_g_last,
   output logic o_g_ready,
   output logic [7:0] o_g_data,
   output logic o_g_ctrl,
   output logic o_g_underrun,
   input wire logic i_x_valid,
   input wire logic [8*LANES-1:0] i_x_data,
   input wire logic i_x_last,
   input wire logic [3:0] i_x_count,
   output logic o_x_ready,
   output logic [8*LANES-1:0] o_x_data,
   output logic [LANES-1:0] o_x_ctrl,
   output logic o_x_underrun
);
   // the start word layout (start, six preamble, delimiter) fills exactly eight lanes
   if (LANES != 8) begin : g_lanes_check
      $error("pcs_tx_inserter: LANES must be 8");
   end

   // 1G path
   gig_state_type g_state_reg;
   gig_state_type g_state_next;
   logic [2:0] g_cnt_reg;
   logic [2:0] g_cnt_next;
   logic g_phase_reg;
   logic [31:0] crc_val;
   logic [7:0] g_byte;
   logic g_ctrl_sel;
   logic [7:0] crc_byte;
   logic [7:0] g_frame_byte;
   logic g_take;
   logic g_in_frame;

   assign g_take = (g_state_reg == G_DATA) && i_g_valid;
   // a gap from the source cannot open a hole mid-frame, so a filler byte is sent
   assign g_frame_byte = i_g_valid ? i_g_data : `UNDERRUN_BYTE;
   assign crc_byte = ~crc_val[{g_cnt_reg[1:0], 3'b000} +: 8];
   assign g_in_frame = (g_state_reg == G_PRE) || (g_state_reg == G_SFD) ||
                       (g_state_reg == G_DATA) || (g_state_reg == G_CRC);

   assign g_byte = (g_state_reg == G_IDLE_K) ? `G_COMMA :
                   (g_state_reg == G_IDLE_D) ? `G_PRESERVE :
                   (g_state_reg == G_START) ? `G_START :
                   (g_state_reg == G_PRE) ? `PREAMBLE_BYTE :
                   (g_state_reg == G_SFD) ? `SFD_BYTE :
                   (g_state_reg == G_DATA) ? g_frame_byte :
                   (g_state_reg == G_CRC) ? crc_byte :
                   (g_state_reg == G_TERM) ? `G_END :
                   (g_state_reg == G_EXT) ? `G_EXTEND :
                   (g_state_reg == G_CORR_K) ? `G_COMMA :
                   `G_CORRECT;

   // flag marks the first byte of each code set only
   assign g_ctrl_sel = !g_in_frame && (g_state_reg != G_IDLE_D) &&
                       (g_state_reg != G_CORR_D);

   always_comb begin
      g_state_next = g_state_reg;
      g_cnt_next = g_cnt_reg;
      unique case (g_state_reg)
         G_IDLE_K: g_state_next = G_IDLE_D;
         G_IDLE_D: begin
            // frames only start on a pair boundary
            g_state_next = i_g_valid ? G_START : G_IDLE_K;
         end
         G_START: begin
            g_state_next = G_PRE;
            g_cnt_next = 3'h0;
         end
         G_PRE: begin
            g_cnt_next = g_cnt_reg + 3'h1;
            if (g_cnt_reg == `G_PRE_LAST) begin
               g_state_next = G_SFD;
            end
         end
         G_SFD: g_state_next = G_DATA;
         G_DATA: begin
            g_cnt_next = 3'h0;
            if (i_g_valid && i_g_last) begin
               g_state_next = G_CRC;
            end
         end
         G_CRC: begin
            g_cnt_next = g_cnt_reg + 3'h1;
            if (g_cnt_reg == `CRC_LAST) begin
               g_state_next = G_TERM;
            end
         end
         G_TERM: g_state_next = G_EXT;
         G_EXT: begin
            // a second extend only when the next slot would be odd
            g_state_next = g_phase_reg ? G_CORR_K : G_EXT;
         end
         G_CORR_K: g_state_next = G_CORR_D;
         G_CORR_D: g_state_next = G_IDLE_K;
         default: g_state_next = G_IDLE_K;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         // reset output is the comma, so the first edge completes the pair
         g_state_reg <= G_IDLE_D;
         g_cnt_reg <= 3'h0;
         g_phase_reg <= 1'b0;
      end else begin
         g_state_reg <= g_state_next;
         g_cnt_reg <= g_cnt_next;
         // parity of the slot being chosen, counted from the start code
         g_phase_reg <= (g_state_reg == G_START) ? 1'b1 : ~g_phase_reg;
      end
   end

   // one byte and its flag leave every clock
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_g_data <= `G_COMMA;
         o_g_ctrl <= 1'b1;
         o_g_underrun <= 1'b0;
      end else begin
         o_g_data <= g_byte;
         o_g_ctrl <= g_ctrl_sel;
         o_g_underrun <= (g_state_reg == G_DATA) && !i_g_valid;
      end
   end

   assign o_g_ready = (g_state_reg == G_DATA);

   crc32_byte u_crc (
      .i_clk(i_clk),
      .i_rst_b(i_rst_b),
      .i_init(g_state_reg == G_START),
      .i_en(g_state_reg == G_DATA),
      .i_data(g_frame_byte),
      .o_crc(crc_val)
   );

   // 10G path
   xg_state_type x_state_reg;
   xg_state_type x_state_next;
   logic [3:0] x_count_eff;
   logic x_end_word;
   logic [8*LANES-1:0] x_word;
   logic [LANES-1:0] x_ctrl_sel;

   // a count of zero or above the lane total means a full last word
   assign x_count_eff = ((i_x_count == 4'h0) || (i_x_count > 4'(LANES))) ?
                        4'(LANES) : i_x_count;
   assign x_end_word = (x_state_reg == X_DATA) && i_x_valid && i_x_last;

   generate
      for (genvar i = 0; i < LANES; i++) begin : g_lane
         logic start_lane;
         logic data_lane;
         logic term_lane;
         logic [7:0] start_byte;
         assign start_lane = (x_state_reg == X_IDLE) && i_x_valid;
         assign data_lane = (x_state_reg == X_DATA) &&
                            (!x_end_word || (4'(i) < x_count_eff));
         assign term_lane = (x_end_word && (4'(i) == x_count_eff)) ||
                            ((x_state_reg == X_TERM) && (i == 0));
         // start takes the first preamble slot, leaving six
         assign start_byte = (i == 0) ? `X_START_CODE :
                             (i == LANES - 1) ? `SFD_BYTE : `PREAMBLE_BYTE;
         assign x_word[8*i +: 8] = start_lane ? start_byte :
                                   data_lane ? (i_x_valid ? i_x_data[8*i +: 8] :
                                                `UNDERRUN_BYTE) :
                                   term_lane ? `X_TERM_CODE : `X_IDLE_CODE;
         assign x_ctrl_sel[i] = start_lane ? (i == 0) : !data_lane;

         chk_lane_codes: assert property (@(posedge i_clk) disable iff (!i_rst_b)
            o_x_ctrl[i] |-> (o_x_data[8*i +: 8] == `X_IDLE_CODE) ||
                            (o_x_data[8*i +: 8] == `X_START_CODE) ||
                            (o_x_data[8*i +: 8] == `X_TERM_CODE))
            else $error("10G control lane carries an unknown code");
      end
   endgenerate

   always_comb begin
      x_state_next = x_state_reg;
      unique case (x_state_reg)
         X_IDLE: x_state_next = i_x_valid ? X_DATA : X_IDLE;
         X_DATA: begin
            if (x_end_word) begin
               // a full last word leaves no lane for the terminate code
               x_state_next = (x_count_eff == 4'(LANES)) ? X_TERM : X_IDLE;
            end
         end
         X_TERM: x_state_next = X_IDLE;
         default: x_state_next = X_IDLE;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         x_state_reg <= X_IDLE;
         o_x_data <= {LANES{`X_IDLE_CODE}};
         o_x_ctrl <= {LANES{1'b1}};
         o_x_underrun <= 1'b0;
      end else begin
         x_state_reg <= x_state_next;
         o_x_data <= x_word;
         o_x_ctrl <= x_ctrl_sel;
         o_x_underrun <= (x_state_reg == X_DATA) && !i_x_valid;
      end
   end

   assign o_x_ready = (x_state_reg == X_DATA);

   // checks
   logic out_odd_reg;
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         out_odd_reg <= 1'b0;
      end else begin
         out_odd_reg <= (o_g_ctrl && (o_g_data == `G_START)) ? 1'b1 : ~out_odd_reg;
      end
   end

   chk_idle_pair_byte: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (o_g_ctrl && (o_g_data == `G_COMMA)) |=>
         !o_g_ctrl && ((o_g_data == `G_PRESERVE) || (o_g_data == `G_CORRECT)))
      else $error("comma not followed by an idle data byte");

   chk_start_preamble: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (o_g_ctrl && (o_g_data == `G_START)) |=>
         (!o_g_ctrl && (o_g_data == `PREAMBLE_BYTE)) [*7] ##1
         (!o_g_ctrl && (o_g_data == `SFD_BYTE)))
      else $error("start code not followed by seven preamble bytes and delimiter");

   chk_start_after_idle: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (o_g_ctrl && (o_g_data == `G_START)) |->
         ($past(o_g_data) == `G_PRESERVE) && !$past(o_g_ctrl))
      else $error("start code not preceded by a complete idle pair");

   chk_end_extend: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (o_g_ctrl && (o_g_data == `G_END)) |=>
         (o_g_ctrl && (o_g_data == `G_EXTEND)) ##1
         (o_g_ctrl && ((o_g_data == `G_EXTEND) || (o_g_data == `G_COMMA))))
      else $error("end code not followed by one or two extends");

   chk_correct_even: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (o_g_ctrl && (o_g_data == `G_COMMA) && $past(o_g_data) == `G_EXTEND) |->
         !out_odd_reg ##1 (o_g_data == `G_CORRECT))
      else $error("correcting idle misplaced after extend");

   chk_crc_span: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (g_state_reg == G_TERM) |->
         ($past(g_state_reg, 5) == G_DATA) && ($past(g_state_reg) == G_CRC))
      else $error("end code not preceded by four crc bytes");

   chk_frame_flag_low: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      g_in_frame |=> !o_g_ctrl)
      else $error("code flag high on a frame byte");

   chk_byte_passes: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      g_take |=> (o_g_data == $past(i_g_data)) && !o_g_ctrl)
      else $error("accepted 1G byte not presented next cycle");

   chk_xg_start_word: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (o_x_ctrl[0] && (o_x_data[7:0] == `X_START_CODE)) |->
         (o_x_ctrl[LANES-1:1] == '0) && (o_x_data[8*LANES-1 -: 8] == `SFD_BYTE) &&
         (o_x_data[55:8] == {6{`PREAMBLE_BYTE}}))
      else $error("10G start word malformed");

   chk_xg_idle_word: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      ((x_state_reg == X_TERM) || ((x_state_reg == X_IDLE) && !i_x_valid)) |=>
         (o_x_ctrl[LANES-1:1] == '1) && (o_x_data[8*LANES-1:8] == {(LANES-1){`X_IDLE_CODE}}))
      else $error("10G lanes after terminate not idle");

   chk_idle_resume: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (g_state_reg == G_CORR_D) |=> (!o_g_ctrl && (o_g_data == `G_CORRECT)) ##1
         (o_g_ctrl && (o_g_data == `G_COMMA)) ##1 (!o_g_ctrl && (o_g_data == `G_PRESERVE)))
      else $error("correcting idle not followed by a preserving pair");

   chk_crc_init: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (g_state_reg == G_SFD) |-> (crc_val == `CRC_INIT))
      else $error("crc not seeded before frame content");

   chk_g_underrun_fill: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      ((g_state_reg == G_DATA) && !i_g_valid) |=>
         o_g_underrun && !o_g_ctrl && (o_g_data == `UNDERRUN_BYTE))
      else $error("1G gap in a frame not filled");

   chk_xg_start_follows: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      ((x_state_reg == X_IDLE) && i_x_valid) |=>
         o_x_ctrl[0] && (o_x_data[7:0] == `X_START_CODE))
      else $error("10G start word missing after valid in idle");

   chk_xg_data_flags: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      ((x_state_reg == X_DATA) && i_x_valid && !i_x_last) |=> (o_x_ctrl == '0))
      else $error("10G data word carries a code flag");

   chk_xg_term_word: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (x_state_reg == X_TERM) |=> o_x_ctrl[0] && (o_x_data[7:0] == `X_TERM_CODE))
      else $error("10G terminate word missing after a full last word");
endmodule // pcs_tx_inserter

// ==== bench/xcvr_model.sv ====
// transceiver-side model that flags any control code it could not encode
`timescale 1ns/1ps
module xcvr_model (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic [7:0] i_g_data,
   input wire logic i_g_ctrl,
   input wire logic [63:0] i_x_data,
   input wire logic [7:0] i_x_ctrl,
   output logic o_bad
);
   logic g_bad;
   logic [7:0] x_bad;
   // a flagged byte outside the code set would leave the encoder as a bad symbol
   assign g_bad = i_g_ctrl & !(i_g_data inside {8'hbc, 8'hfb, 8'hfd, 8'hf7});
   for (genvar l = 0; l < 8; l++) begin : g_lane
      assign x_bad[l] = i_x_ctrl[l] & !(i_x_data[8*l +: 8] inside {8'h07, 8'hfb, 8'hfd});
   end
   // takes one byte and one word every clock, never stalls the block
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_bad <= 1'b0;
      end else if (g_bad | (|x_bad)) begin
         o_bad <= 1'b1;
      end
   end
endmodule // xcvr_model

// ==== bench/tb_top.sv ====
// self-checking bench for the pcs transmit code inserter
`timescale 1ns/1ps
module tb_top;
   logic i_clk, i_rst_b, g_valid, g_last, x_valid, x_last, cap, bad, und, g_und, x_und;
   logic o_g_ready, o_g_ctrl, o_x_ready;
   logic [7:0] g_data, o_g_data, o_x_ctrl;
   logic [63:0] x_data, o_x_data;
   logic [3:0] x_count;
   logic [71:0] gq[$], ge[$], xq[$], xe[$];
   int miscompares, cmp_count, cycles;
   localparam logic [71:0] IDLE = 72'hff0707070707070707;
   pcs_tx_inserter pcs_tx_inserter_i (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_g_valid(g_valid),
      .i_g_data(g_data), .i_g_last(g_last), .o_g_ready(o_g_ready), .o_g_data(o_g_data),
      .o_g_ctrl(o_g_ctrl), .o_g_underrun(g_und), .i_x_valid(x_valid), .i_x_data(x_data),
      .i_x_last(x_last), .i_x_count(x_count), .o_x_ready(o_x_ready), .o_x_data(o_x_data),
      .o_x_ctrl(o_x_ctrl), .o_x_underrun(x_und));
   xcvr_model xcvr_model_i (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_g_data(o_g_data),
      .i_g_ctrl(o_g_ctrl), .i_x_data(o_x_data), .i_x_ctrl(o_x_ctrl), .o_bad(bad));
   initial begin
      i_clk = 1'b0;
      forever #12.5 i_clk = ~i_clk;
   end
   always @(posedge i_clk) begin
      if (cap) begin
         gq.push_back(72'({o_g_ctrl, o_g_data}));
         xq.push_back({o_x_ctrl, o_x_data});
      end
      if (g_und | x_und)
         und = 1'b1;
      cycles++;
      if (cycles == 2000) begin
         miscompares++;
         close_out();
      end
   end
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic cmp(string nm, logic [71:0] exp, logic [71:0] got);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // idle ahead of the start must end on a complete pair, so parity counts back from it
   task automatic check(string nm, ref logic [71:0] e[$], ref logic [71:0] q[$],
         input logic [71:0] ia, input logic [71:0] ib);
      int s;
      s = 0;
      while (s < q.size() && q[s] !== e[0])
         s++;
      for (int j = 0; j < s; j++)
         cmp({nm, " idle"}, ((s - j) % 2) ? ia : ib, q[j]);
      for (int i = 0; i < e.size(); i++)
         cmp(nm, e[i], q[s + i]);
   endtask
   function automatic logic [31:0] crc_step(logic [31:0] c, logic [7:0] d);
      c = c ^ {24'h0, d};
      for (int b = 0; b < 8; b++)
         c = c[0] ? ((c >> 1) ^ 32'hedb88320) : (c >> 1);
      return c;
   endfunction
   function automatic logic [63:0] xword(int w);
      return 64'h8786858483828180 + 64'h0808080808080808 * 64'(w);
   endfunction
   task automatic frame_g(int n);
      logic [31:0] crc;
      int idx;
      crc = 32'hffffffff;
      idx = 0;
      gq.delete();
      ge = {72'h1fb};
      repeat (7) ge.push_back(72'h055);
      ge.push_back(72'h0d5);
      for (int i = 0; i < n; i++) begin
         ge.push_back(72'(8'h10 + 8'(i)));
         crc = crc_step(crc, 8'h10 + 8'(i));
      end
      crc = ~crc;
      for (int i = 0; i < 4; i++)
         ge.push_back(72'(crc[8*i +: 8]));
      ge.push_back(72'h1fd);
      repeat (2 - n % 2) ge.push_back(72'h1f7);
      ge = {ge, 72'h1bc, 72'h0c5, 72'h1bc, 72'h050};
      cap = 1'b1;
      g_valid = 1'b1;
      while (idx < n) begin
         g_data = 8'h10 + 8'(idx);
         g_last = (idx == n - 1);
         @(posedge i_clk);
         if (o_g_ready)
            idx++;
         #1;
      end
      g_valid = 1'b0;
      g_last = 1'b0;
      repeat (20) @(posedge i_clk);
      #1;
      cap = 1'b0;
      check("1G", ge, gq, 72'h050, 72'h1bc);
      $display("test 1G frame of %0d bytes done", n);
   endtask
   // a one-cycle source gap mid-frame becomes a zero byte that the fcs covers
   task automatic gap_g(int n, int k);
      logic [31:0] crc;
      logic [7:0] b;
      int idx;
      crc = 32'hffffffff;
      idx = 0;
      und = 1'b0;
      gq.delete();
      ge = {72'h1fb};
      repeat (7) ge.push_back(72'h055);
      ge.push_back(72'h0d5);
      for (int i = 0; i <= n; i++) begin
         b = (i == k) ? 8'h00 : 8'h10 + 8'(i > k ? i - 1 : i);
         ge.push_back(72'(b));
         crc = crc_step(crc, b);
      end
      crc = ~crc;
      for (int i = 0; i < 4; i++)
         ge.push_back(72'(crc[8*i +: 8]));
      ge.push_back(72'h1fd);
      repeat (2 - (n + 1) % 2) ge.push_back(72'h1f7);
      ge = {ge, 72'h1bc, 72'h0c5, 72'h1bc, 72'h050};
      cap = 1'b1;
      g_valid = 1'b1;
      while (idx < n) begin
         g_data = 8'h10 + 8'(idx);
         g_last = (idx == n - 1);
         @(posedge i_clk);
         if (o_g_ready)
            idx++;
         #1;
         if (idx == k && g_valid && o_g_ready) begin
            g_valid = 1'b0;
            @(posedge i_clk);
            #1;
            g_valid = 1'b1;
         end
      end
      g_valid = 1'b0;
      g_last = 1'b0;
      repeat (20) @(posedge i_clk);
      #1;
      cap = 1'b0;
      check("1G gap", ge, gq, 72'h050, 72'h1bc);
      cmp("underrun pulse", 72'(und), 72'h1);
      und = 1'b0;
      $display("test 1G frame with a gap done");
   endtask
   task automatic frame_x(int nw, int cnt);
      logic [63:0] d;
      logic [7:0] c;
      int idx;
      idx = 0;
      xq.delete();
      xe = {72'h01d5555555555555fb};
      for (int w = 0; w < nw; w++) begin
         d = xword(w);
         c = 8'h00;
         for (int l = 0; l < 8; l++) begin
            if (w == nw - 1 && l >= cnt) begin
               d[8*l +: 8] = (l == cnt) ? 8'hfd : 8'h07;
               c[l] = 1'b1;
            end
         end
         xe.push_back({c, d});
      end
      if (cnt == 8)
         xe.push_back(72'hff07070707070707fd);
      xe.push_back(IDLE);
      cap = 1'b1;
      x_valid = 1'b1;
      x_count = 4'(cnt);
      while (idx < nw) begin
         x_data = xword(idx);
         x_last = (idx == nw - 1);
         @(posedge i_clk);
         if (o_x_ready)
            idx++;
         #1;
      end
      x_valid = 1'b0;
      x_last = 1'b0;
      repeat (6) @(posedge i_clk);
      #1;
      cap = 1'b0;
      check("10G", xe, xq, IDLE, IDLE);
      $display("test 10G frame of %0d words count %0d done", nw, cnt);
   endtask
   initial begin
      i_rst_b = 1'b0;
      {g_valid, g_last, x_valid, x_last, cap, und} = 6'h00;
      g_data = 8'h00;
      x_data = 64'h0;
      x_count = 4'h0;
      miscompares = 0;
      cmp_count = 0;
      cycles = 0;
      repeat (10) @(posedge i_clk);
      #1;
      i_rst_b = 1'b1;
      repeat (5) @(posedge i_clk);
      #1;
      frame_g(1);
      frame_g(5);
      frame_g(6);
      gap_g(4, 2);
      frame_x(1, 1);
      frame_x(3, 5);
      frame_x(2, 8);
      cmp("partner flag", 72'(bad), 72'h0);
      cmp("underrun seen", 72'(und), 72'h0);
      close_out();
   end
endmodule // tb_top
